// [rtl/phy_mii_rx_port.sv]
// Behaviour
// (R01) Received data leaves as a nibble, pin 0 carrying bit 0 up to pin 3 carrying bit 3.
// (R02) Data valid is high only while decoded nibbles are driven, low otherwise.
// (R03) Receive error is high while an error is known in the frame being passed out.
// (R04) In 5B symbol mode the error pin carries symbol bit 4, otherwise it is the error.
// (R05) In RMII operation data bits 2 and 3 are unused and held low; the code sets o_rxd[3:2] to 0 but turns off their output enables.
// (R06) In RMII operation data valid is unused and held low; the error output is optional.
// (R07) Data pins 0 to 2 are sampled at reset as the default operating mode strap.
// (R08) Data pin 3 is sampled at power-up and every reset as the interrupt pin function strap.
// (R09) A high or floating function strap makes the shared pin the active-low interrupt output.
// (R10) A low function strap makes the shared pin the transmit error or symbol bit 4 input.
// (R11) The MAC must not drive data valid or receive error high during reset.
// (R12) The receive clock runs at 25 MHz or 2.5 MHz in MII mode and is unused in RMII mode; the code still clocks its output flops from i_rx_clk in RMII.
// (R13) The MII or RMII choice is latched from the collision strap at reset release.
// (R14) Data, valid and error change only on the receive clock.
`timescale 1ns/100ps
module phy_mii_rx_port (
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic i_rx_clk,
   input wire rx_port_pkg::rx_beat_t i_beat,
   input wire logic i_symbol_mode,
   input wire logic [3:0] i_rxd_pin,
   input wire logic i_col_pin,
   input wire logic i_irq_req,
   input wire logic i_tx_shared_pin,
   output logic [3:0] o_rxd,
   output logic [3:0] o_rxd_oe,
   output logic o_rx_dv,
   output logic o_rx_er,
   output logic o_irq_out_low,
   output logic o_irq_oe,
   output logic o_tx_symbol_bit4,
   output rx_port_pkg::strap_t o_straps
);
   import rx_port_pkg::*;

   // strap pins come from outside: two flops before use
   logic [4:0] strap_meta;
   logic [4:0] strap_sync;
   logic strapping;
   logic irq_sel;
   always_ff @(posedge i_clk) begin
      strap_meta <= {i_col_pin, i_rxd_pin};
      strap_sync <= strap_meta;
   end

   // (R07) (R08) (R13) straps latched while in reset
   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         strapping <= 1'b1;
         o_straps.op_select <= strap_sync[2:0];
         o_straps.irq_strap <= strap_sync[3];
         o_straps.rmii <= strap_sync[4];
      end else begin
         strapping <= 1'b0;
      end
   end

   // shared pin is a pad input: two flops first
   logic tx_meta;
   logic tx_sync;
   always_ff @(posedge i_clk) begin
      tx_meta <= i_tx_shared_pin;
      tx_sync <= tx_meta;
   end

   // (R09) (R10) shared pin role
   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         irq_sel <= IRQ_STRAP_RESET;
         o_irq_out_low <= 1'b1;
         o_irq_oe <= 1'b0;
         o_tx_symbol_bit4 <= 1'b0;
      end else begin
         irq_sel <= o_straps.irq_strap;
         o_irq_out_low <= ~(irq_sel & i_irq_req);
         o_irq_oe <= irq_sel;
         o_tx_symbol_bit4 <= irq_sel ? 1'b0 : tx_sync;
      end
   end

   // hand mode bits over to the link domain; quasi-static after reset
   logic [2:0] cfg_meta;
   logic [2:0] cfg_link;
   logic rst_meta;
   logic rst_link;
   always_ff @(posedge i_rx_clk) begin
      cfg_meta <= {strapping, o_straps.rmii, i_symbol_mode};
      cfg_link <= cfg_meta;
      rst_meta <= i_reset_n;
      rst_link <= rst_meta;
   end

   // (R14) link-side output flops; data pins released while straps sample
   always_ff @(posedge i_rx_clk) begin
      if (!rst_link || cfg_link[2]) begin
         o_rxd <= 4'h0;
         o_rxd_oe <= 4'h0;
         o_rx_dv <= 1'b0;
         o_rx_er <= 1'b0;
      end else begin
         // (R01) (R05) nibble order, upper bits idle in RMII
         o_rxd <= cfg_link[1] ? {2'b00, i_beat.data[1:0]} : (i_beat.valid ? i_beat.data : 4'h0);
         o_rxd_oe <= cfg_link[1] ? 4'h3 : 4'hf;
         // (R02) (R06) valid only with data, never in RMII
         o_rx_dv <= i_beat.valid & ~cfg_link[1];
         // (R03) (R04) error or fifth symbol bit
         o_rx_er <= cfg_link[0] ? i_beat.sym4 : (i_beat.err & i_beat.valid);
      end
   end

   // (R12) clock rate itself is set by the line side; i_rx_clk still clocks the output flops in RMII

   // (R02) valid follows the input beat
   property p_dv_follows;
      @(posedge i_rx_clk) disable iff (!rst_link)
      (!cfg_link[2] && !cfg_link[1] && $stable(cfg_link)) |=> (o_rx_dv == $past(i_beat.valid));
   endproperty
   a_dv_follows: assert property (p_dv_follows) else $error("dv not following valid"); // (R02)

   property p_rmii_quiet;
      @(posedge i_rx_clk) disable iff (!rst_link)
      cfg_link[1] |=> (!o_rx_dv && o_rxd[3:2] == 2'b00);
   endproperty
   a_rmii_quiet: assert property (p_rmii_quiet) else $error("rmii upper bits active"); // (R05)

   property p_er_sym;
      @(posedge i_rx_clk) disable iff (!rst_link)
      (!cfg_link[2] && cfg_link[0]) |=> (o_rx_er == $past(i_beat.sym4));
   endproperty
   a_er_sym: assert property (p_er_sym) else $error("symbol bit 4 wrong"); // (R04)

   property p_er_err;
      @(posedge i_rx_clk) disable iff (!rst_link)
      (!cfg_link[2] && !cfg_link[0] && i_beat.err && i_beat.valid) |=> o_rx_er;
   endproperty
   a_er_err: assert property (p_er_err) else $error("error not flagged"); // (R03)

   property p_nib;
      @(posedge i_rx_clk) disable iff (!rst_link)
      (!cfg_link[2] && !cfg_link[1] && i_beat.valid) |=> (o_rxd == $past(i_beat.data));
   endproperty
   a_nib: assert property (p_nib) else $error("nibble order wrong"); // (R01)

   // last load happens on the final reset edge, so skip that first edge
   property p_strap_hold;
      @(posedge i_clk) disable iff (!i_reset_n)
      $past(i_reset_n) |-> $stable(o_straps);
   endproperty
   a_strap_hold: assert property (p_strap_hold) else $error("strap changed out of reset"); // (R07)

   property p_irq_off;
      @(posedge i_clk) disable iff (!i_reset_n)
      (!irq_sel) |=> (o_irq_out_low && !o_irq_oe);
   endproperty
   a_irq_off: assert property (p_irq_off) else $error("irq driven when strapped low"); // (R10)

   property p_irq_on;
      @(posedge i_clk) disable iff (!i_reset_n)
      (irq_sel && i_irq_req) |=> (!o_irq_out_low && o_irq_oe);
   endproperty
   a_irq_on: assert property (p_irq_on) else $error("irq not asserted"); // (R09)

   property p_strap_load;
      @(posedge i_clk) (!i_reset_n) |=> (o_straps.irq_strap == $past(strap_sync[3]));
   endproperty
   a_strap_load: assert property (p_strap_load) else $error("strap not sampled"); // (R08)

   // (R02) idle nibble is zero
   property p_mii_idle;
      @(posedge i_rx_clk) disable iff (!rst_link)
      (!cfg_link[2] && !cfg_link[1] && !i_beat.valid) |=> (!o_rx_dv && o_rxd == 4'h0);
   endproperty
   a_mii_idle: assert property (p_mii_idle) else $error("idle nibble not quiet"); // (R02)

   // (R03) no error outside frame
   property p_er_quiet;
      @(posedge i_rx_clk) disable iff (!rst_link)
      (!cfg_link[2] && !cfg_link[0] && !i_beat.valid) |=> !o_rx_er;
   endproperty
   a_er_quiet: assert property (p_er_quiet) else $error("error outside frame"); // (R03)

   // (R06) valid unused in RMII
   property p_rmii_dv;
      @(posedge i_rx_clk) disable iff (!rst_link)
      (cfg_link[1] && i_beat.valid) |=> !o_rx_dv;
   endproperty
   a_rmii_dv: assert property (p_rmii_dv) else $error("rmii valid driven"); // (R06)

   // (R07) pins released while strapping
   property p_strap_release;
      @(posedge i_rx_clk) disable iff (!rst_link)
      cfg_link[2] |=> (o_rxd_oe == 4'h0 && !o_rx_dv && !o_rx_er);
   endproperty
   a_strap_release: assert property (p_strap_release) else $error("pins driven in strapping"); // (R07)

   // (R01) all four lanes driven in MII mode
   property p_oe_mii;
      @(posedge i_rx_clk) disable iff (!rst_link)
      (!cfg_link[2] && !cfg_link[1]) |=> (o_rxd_oe == 4'hf);
   endproperty
   a_oe_mii: assert property (p_oe_mii) else $error("mii lanes not driven"); // (R01)

   // (R07) mode strap load
   property p_op_load;
      @(posedge i_clk) (!i_reset_n) |=> (o_straps.op_select == $past(strap_sync[2:0]));
   endproperty
   a_op_load: assert property (p_op_load) else $error("mode strap not sampled"); // (R07)

   // (R13) mii or rmii load
   property p_rmii_load;
      @(posedge i_clk) (!i_reset_n) |=> (o_straps.rmii == $past(strap_sync[4]));
   endproperty
   a_rmii_load: assert property (p_rmii_load) else $error("rmii strap not sampled"); // (R13)

   // (R10) shared pin as input
   property p_tx_bit4;
      @(posedge i_clk) disable iff (!i_reset_n)
      (!irq_sel) |=> (o_tx_symbol_bit4 == $past(tx_sync));
   endproperty
   a_tx_bit4: assert property (p_tx_bit4) else $error("shared pin not passed"); // (R10)

   // (R09) idle interrupt stays high
   property p_irq_idle;
      @(posedge i_clk) disable iff (!i_reset_n)
      (irq_sel && !i_irq_req) |=> (o_irq_out_low && o_irq_oe);
   endproperty
   a_irq_idle: assert property (p_irq_idle) else $error("irq low without request"); // (R09)

   c_frame: cover property (@(posedge i_rx_clk) o_rx_dv ##1 !o_rx_dv);
   c_rmii: cover property (@(posedge i_rx_clk) cfg_link[1] && o_rxd_oe == 4'h3);
   c_err: cover property (@(posedge i_rx_clk) o_rx_dv && o_rx_er);
   c_irq: cover property (@(posedge i_clk) !o_irq_out_low);
endmodule // phy_mii_rx_port

// [rtl/rx_port_pkg.sv]
package rx_port_pkg;
   localparam int NIBBLE_W = 4;
   localparam int OP_SEL_W = 3;
   // reset values of the strap latches
   localparam logic [2:0] OP_SEL_RESET = 3'h7;
   localparam logic IRQ_STRAP_RESET = 1'b1;
   localparam logic RMII_STRAP_RESET = 1'b0;
   // link clock rates in kHz, from the receive clock description
   localparam int RX_CLK_100M_KHZ = 25000;
   localparam int RX_CLK_10M_KHZ = 2500;

   typedef struct packed {
      logic [3:0] data;
      logic valid;
      logic err;
      logic sym4;
   } rx_beat_t;

   typedef struct packed {
      logic [2:0] op_select;
      logic irq_strap;
      logic rmii;
   } strap_t;
endpackage

// [tb/mac_rx_model.sv]
`timescale 1ns/100ps
module mac_rx_model (
   input wire logic i_rx_clk,
   input wire logic [3:0] i_rxd,
   input wire logic i_rx_dv,
   input wire logic i_rx_er,
   output logic [5:0] o_seen
);
   // listens only, sampled on rx clock
   always_ff @(posedge i_rx_clk) begin
      o_seen <= {i_rx_er, i_rx_dv, i_rxd};
   end
endmodule // mac_rx_model

// [tb/phy_mii_receive_port_straps_test.sv]
`timescale 1ns/100ps
module phy_mii_receive_port_straps_test;
   import rx_port_pkg::*;
   logic i_clk = 0, i_rx_clk = 0, i_reset_n = 0, sym = 0, col = 0, irq = 0, txp = 0;
   logic [3:0] pins = 4'h0;
   logic [3:0] rxd, oe;
   logic dv, er, irq_n, irq_oe, txb;
   logic [5:0] seen;
   rx_beat_t beat = '0;
   strap_t st;
   int num_errors = 0, checks_done = 0;
   always #20 i_clk = ~i_clk;
   always #16 i_rx_clk = ~i_rx_clk;
   phy_mii_rx_port i_dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_rx_clk(i_rx_clk),
      .i_beat(beat), .i_symbol_mode(sym), .i_rxd_pin(pins), .i_col_pin(col), .i_irq_req(irq),
      .i_tx_shared_pin(txp), .o_rxd(rxd), .o_rxd_oe(oe), .o_rx_dv(dv), .o_rx_er(er),
      .o_irq_out_low(irq_n), .o_irq_oe(irq_oe), .o_tx_symbol_bit4(txb), .o_straps(st));
   mac_rx_model i_mac (.i_rx_clk(i_rx_clk), .i_rxd(rxd), .i_rx_dv(dv), .i_rx_er(er),
      .o_seen(seen));
   task automatic check(input string what, input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic rx(input int n);
      repeat (n) @(posedge i_rx_clk);
      #2;
   endtask
   task automatic do_reset(input logic [3:0] p, input logic c);
      pins = p;
      col = c;
      i_reset_n = 0;
      repeat (10) @(posedge i_clk);
      #2 i_reset_n = 1;
      rx(6);
      // strap latch must ignore later pin moves
      pins = ~p;
   endtask
   task automatic test_mii_straps;
      do_reset(4'h5, 0);
      check("op_select", st.op_select, 8'h05);
      check("irq_strap", st.irq_strap, 8'h00);
      check("rmii", st.rmii, 8'h00);
      check("irq_oe", irq_oe, 8'h00);
      txp = 1;
      rx(6);
      check("tx_symbol_bit4", txb, 8'h01);
      $display("mii strap test done");
   endtask
   task automatic test_mii_beats;
      beat = '{data: 4'ha, valid: 1'b1, err: 1'b1, sym4: 1'b0};
      rx(3);
      check("rxd", seen[3:0], 8'h0a);
      check("rx_dv", seen[4], 8'h01);
      check("rx_er", seen[5], 8'h01);
      check("mii oe", oe, 8'h0f);
      beat.valid = 0;
      beat.sym4 = 1;
      rx(3);
      check("rx_dv idle", seen[4], 8'h00);
      check("rxd idle", seen[3:0], 8'h00);
      check("er without frame", seen[5], 8'h00);
      sym = 1;
      rx(6);
      check("symbol bit4", seen[5], 8'h01);
      sym = 0;
      beat = '0;
      $display("mii beat test done");
   endtask
   task automatic test_rmii;
      do_reset(4'hf, 1);
      check("rmii", st.rmii, 8'h01);
      check("op_select rmii", st.op_select, 8'h07);
      check("irq_strap", st.irq_strap, 8'h01);
      check("irq_oe", irq_oe, 8'h01);
      irq = 1;
      rx(4);
      check("irq_out_low", irq_n, 8'h00);
      beat = '{data: 4'hf, valid: 1'b1, err: 1'b0, sym4: 1'b0};
      rx(3);
      check("rmii rxd", seen[3:0], 8'h03);
      check("rmii oe", oe, 8'h03);
      check("rmii dv", seen[4], 8'h00);
      $display("rmii test done");
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      test_mii_straps();
      test_mii_beats();
      test_rmii();
      summarize();
   end
   // whole run is a few microseconds
   initial begin
      #200000;
      num_errors++;
      summarize();
   end
endmodule // phy_mii_receive_port_straps_test
